//--- mru_defines.svh
`ifndef MRU_DEFINES_SVH
`define MRU_DEFINES_SVH

// ==========================================================
// register byte offsets on the lite bus
`define MRU_REG_STATUS  8'h00
`define MRU_REG_WDOG    8'h04
`define MRU_REG_RESET   8'h08
`define MRU_REG_EVENT   8'h0c
`define MRU_REG_FCTRL   8'h10
`define MRU_REG_FID     8'h14
`define MRU_REG_FMASK   8'h18
`define MRU_REG_DMASKLO 8'h1c
`define MRU_REG_DMASKHI 8'h20
`define MRU_REG_NVSTAT  8'h24
`define MRU_REG_LOCK    8'h28
`define MRU_REG_GPM     8'h2c

// ==========================================================
// field positions
`define MRU_RST_CNT_LSB  8
`define MRU_RST_LHC_BIT  16
`define MRU_EVT_EN_LSB   8
`define MRU_FC_FILTER_DATA_MASK_ENABLE_BIT  6
`define MRU_FC_IDE_BIT   7
`define MRU_FC_COK_BIT   8
`define MRU_NV_CRC_LSB   8
`define MRU_LOCK_PDC_BIT 16

// ==========================================================
// mode select codes from the mode controller
`define MRU_SEL_STANDBY  3'h0
`define MRU_SEL_NORMAL   3'h1
`define MRU_SEL_SLEEP    3'h2
`define MRU_SEL_OVERTEMP 3'h3
`define MRU_SEL_RESET    3'h4

// ==========================================================
// reset and mode-entry values
`define MRU_OPM_STANDBY  3'h4
`define MRU_OPM_NORMAL   3'h7
`define MRU_OPM_SLEEP    3'h1
`define MRU_WDP_DEFAULT  4'h4
`define MRU_RSS_OVERTEMP 5'h12
`define MRU_RCC_LIMP     2'h3
`define MRU_DMASK_RST    8'hff
`define MRU_DLC_RST      4'h0
`define MRU_FILTER_DATA_MASK_ENABLE_RST     1'h1
`define MRU_RESP_OKAY    2'h0
`define MRU_RESP_SLVERR  2'h2

// ==========================================================
// limp delay: time in microseconds and clock rate in MHz
`define MRU_LIMP_DELAY_US 1000
`define MRU_CLK_MHZ       50

`endif

//--- mru_limp_timer.sv
`timescale 1ns/100ps
// ==========================================================
// limp delay timer: runs while i_run is high, restarts when low
module mru_limp_timer #(
	parameter int CNT_MAX = 50000
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_run,
	output logic      o_elapsed
);
	localparam int W = $clog2(CNT_MAX + 1);

	logic [W-1:0] cnt_ff;

	// count saturates so a long stay never wraps back below the limit
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run) begin
			cnt_ff <= '0;
		end else if (cnt_ff != W'(CNT_MAX)) begin
			cnt_ff <= cnt_ff + W'(1);
		end
	end

	// elapsed once the full delay has passed in the current stay
	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run) begin
			o_elapsed <= 1'b0;
		end else begin
			o_elapsed <= (cnt_ff == W'(CNT_MAX));
		end
	end

	property p_elapse_time;
		@(posedge i_clk) disable iff (i_rst)
		$rose(o_elapsed) |-> $past(i_run) && ($past(cnt_ff) == W'(CNT_MAX));
	endproperty
	a_elapse_time: assert property (p_elapse_time)
		else $error("limp delay flagged before the full count");

endmodule : mru_limp_timer

//--- mru_mode_regs.sv
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "mru_defines.svh"

module mru_mode_regs #(
	parameter int LIMP_DELAY_CYC = `MRU_LIMP_DELAY_US * `MRU_CLK_MHZ,
	parameter int N_LOCK         = 7
) (
	input  wire logic        I_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic        I_MODE_CHG,
	input  wire logic [2:0]  I_MODE_SEL,
	input  wire logic [4:0]  I_RST_SOURCE,
	input  wire logic        I_TX_ACTIVE,
	input  wire logic        I_OTW_LIVE,
	input  wire logic        I_FNM_LIVE,
	input  wire logic        I_SDM_LIVE,
	input  wire logic        I_PNCFG_LIVE,
	input  wire logic        I_CAN_WAKE,
	input  wire logic        I_OTW_EVT,
	input  wire logic        I_FD_EVT,
	input  wire logic        I_NV_FNM_CFG,
	input  wire logic        I_NV_SDM_CFG,
	input  wire logic        I_NV_SLP_CFG,
	input  wire logic [1:0]  I_NV_RLC_CFG,
	input  wire logic        I_NV_ECC,
	input  wire logic        I_NV_PROG,
	input  wire logic [7:0]  I_AXI_AWADDR,
	input  wire logic        I_AXI_AWVALID,
	output logic             O_AXI_AWREADY,
	input  wire logic [31:0] I_AXI_WDATA,
	input  wire logic [3:0]  I_AXI_WSTRB,
	input  wire logic        I_AXI_WVALID,
	output logic             O_AXI_WREADY,
	output logic [1:0]       O_AXI_BRESP,
	output logic             O_AXI_BVALID,
	input  wire logic        I_AXI_BREADY,
	input  wire logic [7:0]  I_AXI_ARADDR,
	input  wire logic        I_AXI_ARVALID,
	output logic             O_AXI_ARREADY,
	output logic [31:0]      O_AXI_RDATA,
	output logic [1:0]       O_AXI_RRESP,
	output logic             O_AXI_RVALID,
	input  wire logic        I_AXI_RREADY,
	output logic [2:0]       O_MODE_CODE,
	output logic             O_LIMP_HOME
);
	// ==========================================================
	// state
	mru_pkg::mru_mode_type mode_ff, nxt_mode;
	logic [2:0]        op_mode_ff;
	logic              nmny_ff, tx_stat_ff;
	logic              otw_st_ff, fnm_st_ff, sdm_st_ff, pncfg_st_ff;
	logic [3:0]        wdp_ff;
	logic [1:0]        rcc_ff;
	logic [4:0]        rss_ff;
	logic              lhc_ff;
	logic [2:0]        evt_ff, evt_en_ff;
	logic [3:0]        dlc_ff;
	logic              filter_data_mask_enable_ff, ide_ff, filter_config_ok_ff;
	logic [31:0]       fid_ff, fmask_ff, gpm_ff;
	logic [7:0]        dmask_ff [0:7];
	logic [7:0]        crc_ff;
	logic [N_LOCK-1:0] lock_ff;
	logic              pdc_ff;
	logic              limp_elapsed;
	logic              limp_mode;
	logic              mode_ok, enter_ot, enter_rst;
	logic [7:0]        aw_addr_ff;
	logic [31:0]       wdata_ff;
	logic [3:0]        wstrb_ff;
	logic              aw_full_ff, w_full_ff;
	logic              wr_go, wr_commit;
	logic [31:0]       wval;

	// ==========================================================
	// helper functions
	function automatic mru_pkg::mru_mode_type sel_to_mode(
		input logic [2:0] s);
		unique case (s)
			`MRU_SEL_STANDBY:  sel_to_mode = mru_pkg::MODE_STANDBY;
			`MRU_SEL_NORMAL:   sel_to_mode = mru_pkg::MODE_NORMAL;
			`MRU_SEL_SLEEP:    sel_to_mode = mru_pkg::MODE_SLEEP;
			`MRU_SEL_OVERTEMP: sel_to_mode = mru_pkg::MODE_OVERTEMP;
			default:           sel_to_mode = mru_pkg::MODE_RESET;
		endcase
	endfunction : sel_to_mode

	// register word seen by software at a byte address
	function automatic logic [31:0] reg_word(input logic [7:0] a);
		reg_word = 32'h0;
		unique case ({a[7:2], 2'b00})
			`MRU_REG_STATUS: reg_word = {23'h0, pncfg_st_ff, sdm_st_ff,
				fnm_st_ff, otw_st_ff, tx_stat_ff, nmny_ff, op_mode_ff};
			`MRU_REG_WDOG:   reg_word[3:0] = wdp_ff;
			`MRU_REG_RESET: begin
				reg_word[4:0] = rss_ff;
				reg_word[`MRU_RST_CNT_LSB +: 2] = rcc_ff;
				reg_word[`MRU_RST_LHC_BIT] = lhc_ff;
			end
			`MRU_REG_EVENT: begin
				reg_word[2:0] = evt_ff;
				reg_word[`MRU_EVT_EN_LSB +: 3] = evt_en_ff;
			end
			`MRU_REG_FCTRL: begin
				reg_word[3:0] = dlc_ff;
				reg_word[`MRU_FC_FILTER_DATA_MASK_ENABLE_BIT] = filter_data_mask_enable_ff;
				reg_word[`MRU_FC_IDE_BIT] = ide_ff;
				reg_word[`MRU_FC_COK_BIT] = filter_config_ok_ff;
			end
			`MRU_REG_FID:     reg_word = fid_ff;
			`MRU_REG_FMASK:   reg_word = fmask_ff;
			`MRU_REG_DMASKLO: reg_word = {dmask_ff[3], dmask_ff[2],
				dmask_ff[1], dmask_ff[0]};
			`MRU_REG_DMASKHI: reg_word = {dmask_ff[7], dmask_ff[6],
				dmask_ff[5], dmask_ff[4]};
			// nonvolatile fields come straight from the store, never latched
			`MRU_REG_NVSTAT: begin
				reg_word[6:0] = {I_NV_PROG, I_NV_ECC, I_NV_RLC_CFG,
					I_NV_SLP_CFG, I_NV_SDM_CFG, I_NV_FNM_CFG};
				reg_word[`MRU_NV_CRC_LSB +: 8] = crc_ff;
			end
			`MRU_REG_LOCK: begin
				reg_word[N_LOCK-1:0] = lock_ff;
				reg_word[`MRU_LOCK_PDC_BIT] = pdc_ff;
			end
			`MRU_REG_GPM:     reg_word = gpm_ff;
			default:          reg_word = 32'h0;
		endcase
	endfunction : reg_word

	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = (a[1:0] == 2'b00) && (a <= `MRU_REG_GPM);
	endfunction : reg_mapped

	function automatic logic wr_hit(input logic [7:0] off);
		wr_hit = wr_commit && ({aw_addr_ff[7:2], 2'b00} == off);
	endfunction : wr_hit

	// ==========================================================
	// mode tracking; illegal select codes are ignored
	assign mode_ok   = I_MODE_CHG && (I_MODE_SEL <= `MRU_SEL_RESET);
	assign nxt_mode  = mode_ok ? sel_to_mode(I_MODE_SEL) : mode_ff;
	assign enter_ot  = mode_ok && (nxt_mode == mru_pkg::MODE_OVERTEMP);
	assign enter_rst = mode_ok && (nxt_mode == mru_pkg::MODE_RESET);

	// every mode-entry field below keys off the same edge as mode_ff
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			mode_ff <= mru_pkg::MODE_OFF;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// overtemp leaves the code alone since its value is not defined there
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			op_mode_ff <= `MRU_OPM_STANDBY;
		end else if (mode_ok) begin
			unique case (nxt_mode)
				mru_pkg::MODE_NORMAL:   op_mode_ff <= `MRU_OPM_NORMAL;
				mru_pkg::MODE_SLEEP:    op_mode_ff <= `MRU_OPM_SLEEP;
				mru_pkg::MODE_OVERTEMP: op_mode_ff <= op_mode_ff;
				default:                op_mode_ff <= `MRU_OPM_STANDBY;
			endcase
		end
	end

	// transmitter status gated by the mode about to be active
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			tx_stat_ff <= 1'b0;
		end else begin
			tx_stat_ff <= (nxt_mode == mru_pkg::MODE_NORMAL) && I_TX_ACTIVE;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			nmny_ff <= 1'b1;
		end else if (mode_ok && nxt_mode == mru_pkg::MODE_NORMAL) begin
			nmny_ff <= 1'b0;
		end
	end

	// live status, zero only during power-on
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			{otw_st_ff, fnm_st_ff, sdm_st_ff, pncfg_st_ff} <= 4'h0;
		end else begin
			otw_st_ff   <= I_OTW_LIVE;
			fnm_st_ff   <= I_FNM_LIVE;
			sdm_st_ff   <= I_SDM_LIVE;
			pncfg_st_ff <= I_PNCFG_LIVE;
		end
	end

	// watchdog period: mode reload beats a software write in one cycle
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || enter_ot || enter_rst) begin
			wdp_ff <= `MRU_WDP_DEFAULT;
		end else if (wr_hit(`MRU_REG_WDOG)) begin
			wdp_ff <= wval[3:0];
		end
	end

	// reset counter wraps after three, as a two-bit field must
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			rcc_ff <= 2'h0;
		end else if (enter_rst) begin
			rcc_ff <= rcc_ff + 2'h1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			rss_ff <= 5'h00;
		end else if (enter_ot) begin
			rss_ff <= `MRU_RSS_OVERTEMP;
		end else if (enter_rst) begin
			rss_ff <= I_RST_SOURCE;
		end
	end

	// ==========================================================
	// limp-home control
	// the delay only counts while the device sits in overtemp or reset
	assign limp_mode = (mode_ff == mru_pkg::MODE_OVERTEMP) ||
		(mode_ff == mru_pkg::MODE_RESET);

	mru_limp_timer #(
		.CNT_MAX (LIMP_DELAY_CYC)
	) u_limp_timer (
		.i_clk     (I_CLK),
		.i_rst     (I_SYS_RST),
		.i_run     (limp_mode),
		.o_elapsed (limp_elapsed)
	);

	// hardware set wins over a software clear in the same cycle;
	// elapsed lags a mode exit by one edge, so it is gated by the mode
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			lhc_ff <= 1'b0;
		end else if ((limp_elapsed && limp_mode) ||
				(mode_ff == mru_pkg::MODE_RESET &&
				rcc_ff == `MRU_RCC_LIMP)) begin
			lhc_ff <= 1'b1;
		end else if (wr_hit(`MRU_REG_RESET)) begin
			lhc_ff <= wval[`MRU_RST_LHC_BIT];
		end
	end

	// ==========================================================
	// events: write one to clear, a new event wins over the clear
	generate
		for (genvar g = 0; g < 3; g++) begin : g_evt
			logic evt_in;
			assign evt_in = (g == 0) ? I_CAN_WAKE :
				(g == 1) ? I_OTW_EVT : I_FD_EVT;
			always_ff @(posedge I_CLK) begin
				if (I_SYS_RST) begin
					evt_ff[g] <= 1'b0;
				end else if (evt_in) begin
					evt_ff[g] <= 1'b1;
				end else if (wr_hit(`MRU_REG_EVENT) && wstrb_ff[0] &&
						wdata_ff[g]) begin
					evt_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			evt_en_ff <= 3'h0;
		end else if (wr_hit(`MRU_REG_EVENT)) begin
			evt_en_ff <= wval[`MRU_EVT_EN_LSB +: 3];
		end
	end

	// ==========================================================
	// frame filter configuration, only power-on resets it
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			dlc_ff   <= `MRU_DLC_RST;
			filter_data_mask_enable_ff  <= `MRU_FILTER_DATA_MASK_ENABLE_RST;
			ide_ff   <= 1'b0;
			filter_config_ok_ff <= 1'b0;
		end else if (wr_hit(`MRU_REG_FCTRL)) begin
			dlc_ff   <= wval[3:0];
			filter_data_mask_enable_ff  <= wval[`MRU_FC_FILTER_DATA_MASK_ENABLE_BIT];
			ide_ff   <= wval[`MRU_FC_IDE_BIT];
			filter_config_ok_ff <= wval[`MRU_FC_COK_BIT];
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			fid_ff   <= 32'h0;
			fmask_ff <= 32'h0;
		end else begin
			if (wr_hit(`MRU_REG_FID)) begin
				fid_ff <= wval;
			end
			if (wr_hit(`MRU_REG_FMASK)) begin
				fmask_ff <= wval;
			end
		end
	end

	generate
		for (genvar d = 0; d < 8; d++) begin : g_dmask
			always_ff @(posedge I_CLK) begin
				if (I_SYS_RST) begin
					dmask_ff[d] <= `MRU_DMASK_RST;
				end else if (wr_hit((d < 4) ? `MRU_REG_DMASKLO :
						`MRU_REG_DMASKHI)) begin
					dmask_ff[d] <= wval[(d % 4) * 8 +: 8];
				end
			end
		end
	endgenerate

	// ==========================================================
	// scratch, checksum control, locks and power distribution
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			crc_ff <= 8'h00;
			gpm_ff <= 32'h0;
		end else begin
			if (wr_hit(`MRU_REG_NVSTAT)) begin
				crc_ff <= wval[`MRU_NV_CRC_LSB +: 8];
			end
			if (wr_hit(`MRU_REG_GPM)) begin
				gpm_ff <= wval;
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			lock_ff <= '0;
			pdc_ff  <= 1'b0;
		end else if (wr_hit(`MRU_REG_LOCK)) begin
			lock_ff <= wval[N_LOCK-1:0];
			pdc_ff  <= wval[`MRU_LOCK_PDC_BIT];
		end
	end

	// ==========================================================
	// lite bus write side: address and data taken in either order
	assign wr_go     = aw_full_ff && w_full_ff && !O_AXI_BVALID;
	// unmapped or misaligned addresses must never reach a register
	assign wr_commit = wr_go && !mode_ok && reg_mapped(aw_addr_ff);

	// merge strobed bytes over the current word
	always_comb begin
		wval = reg_word(aw_addr_ff);
		for (int b = 0; b < 4; b++) begin
			if (wstrb_ff[b]) begin
				wval[b*8 +: 8] = wdata_ff[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			aw_full_ff    <= 1'b0;
			O_AXI_AWREADY <= 1'b1;
			aw_addr_ff    <= 8'h00;
		end else if (I_AXI_AWVALID && O_AXI_AWREADY) begin
			aw_full_ff    <= 1'b1;
			O_AXI_AWREADY <= 1'b0;
			aw_addr_ff    <= I_AXI_AWADDR;
		end else if (O_AXI_BVALID && I_AXI_BREADY) begin
			aw_full_ff    <= 1'b0;
			O_AXI_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			w_full_ff    <= 1'b0;
			O_AXI_WREADY <= 1'b1;
			wdata_ff     <= 32'h0;
			wstrb_ff     <= 4'h0;
		end else if (I_AXI_WVALID && O_AXI_WREADY) begin
			w_full_ff    <= 1'b1;
			O_AXI_WREADY <= 1'b0;
			wdata_ff     <= I_AXI_WDATA;
			wstrb_ff     <= I_AXI_WSTRB;
		end else if (O_AXI_BVALID && I_AXI_BREADY) begin
			w_full_ff    <= 1'b0;
			O_AXI_WREADY <= 1'b1;
		end
	end

	// a write colliding with a mode change is dropped and answered slverr
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_AXI_BVALID <= 1'b0;
			O_AXI_BRESP  <= `MRU_RESP_OKAY;
		end else if (wr_go) begin
			O_AXI_BVALID <= 1'b1;
			O_AXI_BRESP  <= (mode_ok || !reg_mapped(aw_addr_ff)) ?
				`MRU_RESP_SLVERR : `MRU_RESP_OKAY;
		end else if (I_AXI_BREADY) begin
			O_AXI_BVALID <= 1'b0;
		end
	end

	// ==========================================================
	// lite bus read side: one outstanding read, data one cycle after
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_AXI_ARREADY <= 1'b1;
			O_AXI_RVALID  <= 1'b0;
			O_AXI_RDATA   <= 32'h0;
			O_AXI_RRESP   <= `MRU_RESP_OKAY;
		end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
			O_AXI_ARREADY <= 1'b0;
			O_AXI_RVALID  <= 1'b1;
			if (mode_ok || !reg_mapped(I_AXI_ARADDR)) begin
				O_AXI_RDATA <= 32'h0;
				O_AXI_RRESP <= `MRU_RESP_SLVERR;
			end else begin
				O_AXI_RDATA <= reg_word(I_AXI_ARADDR);
				O_AXI_RRESP <= `MRU_RESP_OKAY;
			end
		end else if (O_AXI_RVALID && I_AXI_RREADY) begin
			O_AXI_ARREADY <= 1'b1;
			O_AXI_RVALID  <= 1'b0;
		end
	end

	// pin-facing copies, registered so they match the register view
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_MODE_CODE <= `MRU_OPM_STANDBY;
			O_LIMP_HOME <= 1'b0;
		end else begin
			O_MODE_CODE <= op_mode_ff;
			O_LIMP_HOME <= lhc_ff;
		end
	end

	// ==========================================================
	// checks
	property p_mode_code;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(mode_ok && nxt_mode != mru_pkg::MODE_OVERTEMP) |=>
			(mode_ff == mru_pkg::MODE_NORMAL) ==
			(op_mode_ff == `MRU_OPM_NORMAL);
	endproperty
	a_mode_code: assert property (p_mode_code)
		else $error("mode code does not match entered mode");

	property p_tx_gate;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(mode_ff != mru_pkg::MODE_NORMAL) |-> !tx_stat_ff;
	endproperty
	a_tx_gate: assert property (p_tx_gate)
		else $error("transmitter status set outside normal mode");

	property p_nmny_fall;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		$fell(nmny_ff) |-> $past(mode_ok) &&
			($past(I_MODE_SEL) == `MRU_SEL_NORMAL);
	endproperty
	a_nmny_fall: assert property (p_nmny_fall)
		else $error("normal flag cleared without entering normal");

	property p_wdp_reload;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(enter_ot || enter_rst) |=> (wdp_ff == `MRU_WDP_DEFAULT);
	endproperty
	a_wdp_reload: assert property (p_wdp_reload)
		else $error("watchdog period not reloaded on mode entry");

	property p_rcc_step;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!$past(I_SYS_RST) |-> (rcc_ff == $past(rcc_ff) +
			2'($past(enter_rst)));
	endproperty
	a_rcc_step: assert property (p_rcc_step)
		else $error("reset counter moved without a reset entry");

	property p_rss_ot;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		enter_ot |=> (rss_ff == `MRU_RSS_OVERTEMP) ##1
			((rss_ff == `MRU_RSS_OVERTEMP) || $past(enter_rst));
	endproperty
	a_rss_ot: assert property (p_rss_ot)
		else $error("reset cause wrong after overtemp entry");

	property p_limp_cnt;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(mode_ff == mru_pkg::MODE_RESET && rcc_ff == `MRU_RCC_LIMP)
			|=> lhc_ff ##1 O_LIMP_HOME;
	endproperty
	a_limp_cnt: assert property (p_limp_cnt)
		else $error("limp bit not set at reset count three");

	property p_live_otw;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!$past(I_SYS_RST) |-> (otw_st_ff == $past(I_OTW_LIVE));
	endproperty
	a_live_otw: assert property (p_live_otw)
		else $error("overtemp warning status not tracking");

	property p_evt_set;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(I_CAN_WAKE || (evt_ff[0] && !wr_commit)) |=> evt_ff[0];
	endproperty
	a_evt_set: assert property (p_evt_set)
		else $error("wake event lost");

	property p_discard;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(wr_go && mode_ok) |=> O_AXI_BVALID &&
			(O_AXI_BRESP == `MRU_RESP_SLVERR) && $stable(gpm_ff) &&
			($stable(wdp_ff) || $past(enter_ot || enter_rst));
	endproperty
	a_discard: assert property (p_discard)
		else $error("colliding write not discarded");

endmodule : mru_mode_regs

//--- mru_mode_regs_tb.sv
`timescale 1ns/100ps
// ==========================================================
// bench: register reads and writes around mode changes
module mru_mode_regs_tb;
	localparam logic [31:0] POV [12] = '{32'hc, 32'h4, 32'h0, 32'h0,
		32'h40, 32'h0, 32'h0, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0,
		32'h0};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        chg = 1'b0;
	logic [2:0]  sel = 3'h0;
	logic [4:0]  src = 5'h0;
	logic [3:0]  live = 4'h0;
	logic [2:0]  evt = 3'h0;
	logic [6:0]  nv = 7'h0;
	logic        tx = 1'b0;
	logic [7:0]  awa = 8'h0;
	logic [7:0]  ara = 8'h0;
	logic [31:0] wd = 32'h0;
	logic [3:0]  stb = 4'hf;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        brd = 1'b0;
	logic        arv = 1'b0;
	logic        rrd = 1'b0;
	logic        awr, wr, bv, arr, rv, limp;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [2:0]  code;
	int          num_errors = 0;
	int          cmp_count = 0;

	// limp delay shortened so the overtemp case stays brief
	mru_mode_regs #(.LIMP_DELAY_CYC(10)) dut (.I_CLK(clk), .I_SYS_RST(rst),
		.I_MODE_CHG(chg), .I_MODE_SEL(sel), .I_RST_SOURCE(src),
		.I_TX_ACTIVE(tx), .I_OTW_LIVE(live[0]), .I_FNM_LIVE(live[1]),
		.I_SDM_LIVE(live[2]), .I_PNCFG_LIVE(live[3]), .I_CAN_WAKE(evt[0]),
		.I_OTW_EVT(evt[1]), .I_FD_EVT(evt[2]), .I_NV_FNM_CFG(nv[0]),
		.I_NV_SDM_CFG(nv[1]), .I_NV_SLP_CFG(nv[2]), .I_NV_RLC_CFG(nv[4:3]),
		.I_NV_ECC(nv[5]), .I_NV_PROG(nv[6]), .I_AXI_AWADDR(awa),
		.I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_WDATA(wd),
		.I_AXI_WSTRB(stb), .I_AXI_WVALID(wv), .O_AXI_WREADY(wr),
		.O_AXI_BRESP(bresp), .O_AXI_BVALID(bv), .I_AXI_BREADY(brd),
		.I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
		.O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv),
		.I_AXI_RREADY(rrd), .O_MODE_CODE(code), .O_LIMP_HOME(limp));

	// ==========================================================
	// clock and helpers
	always #10 clk = ~clk;

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// write: both channels offered at once, each released when taken;
	// c raises a mode change in the cycle in which the write commits
	task automatic wreg(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e, input logic c = 1'b0);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do begin
			@(posedge clk);
			if (c && awv && wv && awr && wr) chg <= 1'b1;
			else if (chg) chg <= 1'b0;
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		chk({bresp, 32'h0}, {e, 32'h0});
	endtask : wreg

	// read and compare; c raises a mode change in the address cycle
	task automatic rchk(input logic [7:0] a, input logic [31:0] x,
		input logic [1:0] e, input logic c = 1'b0);
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		if (c) chg <= 1'b1;
		do begin
			@(posedge clk);
			if (chg) chg <= 1'b0;
			if (arr) arv <= 1'b0;
		end while (!rv);
		chk({rresp, rdata}, {e, x});
	endtask : rchk

	// one mode change pulse, then one settling cycle
	task automatic go(input logic [2:0] s);
		chg <= 1'b1;
		sel <= s;
		@(posedge clk);
		chg <= 1'b0;
		@(posedge clk);
	endtask : go

	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	// ==========================================================
	// test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 12; i++) rchk(8'(i * 4), POV[i], 2'h0);
		wreg(8'h28, 32'h1007f, 2'h0);
		wreg(8'h2c, 32'ha55a3cc3, 2'h0);
		tx <= 1'b1;
		go(3'h1);
		rchk(8'h00, 32'h17, 2'h0);
		chk(34'(code), 34'h7);
		go(3'h2);
		rchk(8'h00, 32'h1, 2'h0);
		go(3'h5);
		rchk(8'h00, 32'h1, 2'h0);
		wreg(8'h04, 32'h9, 2'h0);
		go(3'h0);
		rchk(8'h04, 32'h9, 2'h0);
		rchk(8'h00, 32'h4, 2'h0);
		src <= 5'h0b;
		go(3'h4);
		go(3'h0);
		rchk(8'h08, 32'h10b, 2'h0);
		rchk(8'h04, 32'h4, 2'h0);
		go(3'h4);
		go(3'h0);
		go(3'h4);
		repeat (2) @(posedge clk);
		chk(34'(limp), 34'h1);
		go(3'h0);
		rchk(8'h08, 32'h1030b, 2'h0);
		wreg(8'h08, 32'h0, 2'h0);
		wreg(8'h04, 32'h9, 2'h0);
		go(3'h3);
		repeat (20) @(posedge clk);
		rchk(8'h08, 32'h10312, 2'h0);
		rchk(8'h04, 32'h4, 2'h0);
		go(3'h0);
		live <= 4'hf;
		nv <= 7'h7f;
		evt <= 3'h7;
		@(posedge clk);
		evt <= 3'h0;
		@(posedge clk);
		rchk(8'h00, 32'h1e4, 2'h0);
		rchk(8'h24, 32'h7f, 2'h0);
		go(3'h1);
		rchk(8'h24, 32'h7f, 2'h0);
		rchk(8'h0c, 32'h7, 2'h0);
		wreg(8'h0c, 32'h707, 2'h0);
		rchk(8'h0c, 32'h700, 2'h0);
		rchk(8'h00, 32'h0, 2'h2, 1'b1);
		rchk(8'h30, 32'h0, 2'h2);
		wreg(8'h30, 32'h1, 2'h2);
		wreg(8'h2c, 32'h0, 2'h2, 1'b1);
		wreg(8'h05, 32'h1, 2'h2);
		rchk(8'h04, 32'h4, 2'h0);
		stb <= 4'h2;
		wreg(8'h14, 32'h12345678, 2'h0);
		stb <= 4'hf;
		rchk(8'h14, 32'h5600, 2'h0);
		rchk(8'h28, 32'h1007f, 2'h0);
		rchk(8'h2c, 32'ha55a3cc3, 2'h0);
		rchk(8'h1c, 32'hffffffff, 2'h0);
		rchk(8'h10, 32'h40, 2'h0);
		complete_run();
	end

	// hang guard: the sequence needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule : mru_mode_regs_tb

//--- mru_pkg.sv
package mru_pkg;

	// ==========================================================
	// operating modes, one-hot
	typedef enum logic [5:0] {
		MODE_OFF      = 6'h01,
		MODE_STANDBY  = 6'h02,
		MODE_NORMAL   = 6'h04,
		MODE_SLEEP    = 6'h08,
		MODE_OVERTEMP = 6'h10,
		MODE_RESET    = 6'h20
	} mru_mode_type;

endpackage : mru_pkg
